/* core/mcc_if.sv */
/*
 Interface joining the transceiver status end and the MAC/manager end.
 Assumes the bench resolves the shared management data wire from enables.
*/
`timescale 1ns/1ns
interface mcc_if;
    logic carrier_sense;
    logic collision;
    logic speed_indicator;
    logic hw_reset_low;
    logic tx_enable;
    logic ref_clk;
    logic mdc;
    logic mdio_in;
    logic phy_mdio_out;
    logic phy_mdio_oe_n;
    logic sta_mdio_out;
    logic sta_mdio_oe_n;
    modport phy (
        output carrier_sense, collision, speed_indicator,
        output phy_mdio_out, phy_mdio_oe_n,
        input hw_reset_low, tx_enable, ref_clk, mdc, mdio_in
    );
    modport mac (
        input carrier_sense, collision, speed_indicator, phy_mdio_out,
        input phy_mdio_oe_n, mdio_in,
        output hw_reset_low, tx_enable, ref_clk, mdc,
        output sta_mdio_out, sta_mdio_oe_n
    );
endinterface

/* core/mcc_mac.sv */
/*
 MAC and station manager end: AXI4-Lite registers, reset pin, MDC divider,
 heartbeat suppress write over MDIO, synchronised carrier/collision status.
 Assumes a single clk domain and an AXI4-Lite master.
*/
`timescale 1ns/1ns
module mcc_mac
    import mcc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    mcc_if.mac link,
    input wire logic tx_request,
    input wire logic ref_osc,
    input wire logic [4:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    input wire logic [4:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    typedef struct packed {
        logic aw_got;
        logic [4:0] aw;
        logic w_got;
        logic [31:0] w;
        logic [3:0] ws;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [CTRL_W-1:0] ctrl;
        logic col_seen;
        logic [2:0] div;
        logic mdc;
        logic [5:0] bit_cnt;
        logic [31:0] frame;
        logic busy;
        logic last_hbs;
    } mcc_mac_s;
    mcc_mac_s st_q;
    mcc_mac_s st_d;
    logic crs_s;
    logic col_s;
    logic [1:0] s_vec;

    mcc_sync #(.W(2)) u_sync (
        .clk(clk),
        .reset(reset),
        .d({link.carrier_sense, link.collision}),
        .q(s_vec)
    );
    assign crs_s = s_vec[1];
    assign col_s = s_vec[0];

    always_comb begin
        st_d = st_q;
        if (s_awvalid && !st_q.aw_got) begin
            st_d.aw_got = 1'b1;
            st_d.aw = s_awaddr;
        end
        if (s_wvalid && !st_q.w_got) begin
            st_d.w_got = 1'b1;
            st_d.w = s_wdata;
            st_d.ws = s_wstrb;
        end
        if (st_q.aw_got && st_q.w_got && !st_q.bvalid) begin
            st_d.aw_got = 1'b0;
            st_d.w_got = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = RESP_OKAY;
            if (st_q.aw == OFF_CTRL) begin
                if (st_q.ws[0]) begin
                    st_d.ctrl = st_q.w[CTRL_W-1:0];
                end
            end else if (st_q.aw == OFF_STATUS) begin
                if (st_q.ws[0] && st_q.w[STAT_COLSEEN_BIT]) begin
                    st_d.col_seen = 1'b0;
                end
            end else begin
                st_d.bresp = RESP_SLVERR;
            end
        end
        if (st_q.bvalid && s_bready) begin
            st_d.bvalid = 1'b0;
        end
        if (s_arvalid && !st_q.rvalid) begin
            st_d.rvalid = 1'b1;
            st_d.rresp = RESP_OKAY;
            st_d.rdata = 32'h00000000;
            if (s_araddr == OFF_CTRL) begin
                st_d.rdata[CTRL_W-1:0] = st_q.ctrl;
            end else if (s_araddr == OFF_STATUS) begin
                st_d.rdata[STAT_CRS_BIT] = crs_s;
                st_d.rdata[STAT_COL_BIT] = col_s;
                st_d.rdata[STAT_SPEED_BIT] = link.speed_indicator;
                st_d.rdata[STAT_COLSEEN_BIT] = st_q.col_seen;
            end else begin
                st_d.rresp = RESP_SLVERR;
            end
        end
        if (st_q.rvalid && s_rready) begin
            st_d.rvalid = 1'b0;
        end
        if (col_s) begin
            st_d.col_seen = 1'b1;
        end
        // MDC divider, the manager owns this clock
        st_d.div = st_q.div + 3'h1;
        if (st_q.div == 3'(MDC_DIV - 1)) begin
            st_d.div = 3'h0;
            st_d.mdc = !st_q.mdc;
            // Shift a new bit on the falling MDC edge
            if (st_q.mdc && st_q.busy) begin
                st_d.frame = {st_q.frame[30:0], 1'b1};
                st_d.bit_cnt = st_q.bit_cnt + 6'h01;
                if (st_q.bit_cnt == 6'h3F) begin
                    st_d.busy = 1'b0;
                end
            end
        end
        // Write heartbeat suppress to the device when it changes
        // Start in the low MDC phase so the first rise samples bit 31
        if (!st_q.busy && st_q.ctrl[CTRL_HBSUP_BIT] != st_q.last_hbs
            && st_q.ctrl[CTRL_RESET_BIT] == 1'b0 && !st_q.mdc) begin
            st_d.busy = 1'b1;
            st_d.bit_cnt = 6'h00;
            st_d.last_hbs = st_q.ctrl[CTRL_HBSUP_BIT];
            st_d.frame = {2'h1, 2'h1, 5'h00, HB_SUPPRESS_REG, 2'h2,
                13'h0000, st_q.ctrl[CTRL_HBSUP_BIT], 2'h0};
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= '0;
            st_q.ctrl <= CTRL_RESET_VAL;
        end else begin
            st_q <= st_d;
        end
    end

    assign s_awready = !st_q.aw_got;
    assign s_wready = !st_q.w_got;
    assign s_bvalid = st_q.bvalid;
    assign s_bresp = st_q.bresp;
    assign s_arready = !st_q.rvalid;
    assign s_rvalid = st_q.rvalid;
    assign s_rresp = st_q.rresp;
    assign s_rdata = st_q.rdata;
    assign link.hw_reset_low = !st_q.ctrl[CTRL_RESET_BIT];
    assign link.tx_enable = tx_request;
    assign link.ref_clk = ref_osc;
    assign link.mdc = st_q.mdc;
    assign link.sta_mdio_out = st_q.busy ? st_q.frame[31] : 1'b1;
    assign link.sta_mdio_oe_n = !st_q.busy;
endmodule

/* core/mcc_phy.sv */
/*
 Transceiver end: carrier sense, collision, heartbeat, speed indicator,
 reset and a small management serial slave clocked by sampled MDC edges.
 Assumes receive activity inputs come from the analog front end.
*/
// The address map and the AXI4-Lite slave port were chosen for this implementation.
// Behaviour
// - Speed indicator low 10M, high 100M
// - Reset pin low holds block in reset
// - Collision on receive activity while transmitting
// - 10M activity from unsquelched receive signal
// - 100M activity: two non-adjacent zeros in symbol
// - Collision not synchronised to data clocks
// - Full duplex forces collision low
// - Heartbeat collision pulse unless suppress bit set
// - Half duplex: carrier on receive or transmit
// - Full duplex or repeater: carrier on receive
// - Carrier not synchronised to data clocks
// - Manager sources MDC, device only receives
// - Management transfers timed by MDC
// - Board supplies 25 MHz reference clock; the bench toggles ref_osc every 80 ns, giving 6.25 MHz
// - Either side drives MDIO, referenced to MDC
`timescale 1ns/1ns
module mcc_phy
    import mcc_pkg::*;
#(
    parameter int SYMW = SYM_W
) (
    input wire logic clk,
    input wire logic reset,
    mcc_if.phy link,
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic repeater_mode,
    input wire logic rx_unsquelched,
    input wire logic [SYMW-1:0] rx_symbol,
    output logic ref_clk_seen
);
    typedef enum logic [1:0] {HB_IDLE, HB_WAIT, HB_PULSE} mcc_hb_e;
    typedef struct packed {
        logic mdc_prev;
        logic ref_prev;
        logic ref_seen;
        logic tx_prev;
        mcc_hb_e hb;
        logic [7:0] hb_cnt;
        logic hb_suppress;
        logic [5:0] bit_cnt;
        logic [15:0] sh;
        logic [4:0] reg_addr;
        logic is_read;
        logic drive;
        logic mdio_out;
    } mcc_phy_s;
    mcc_phy_s st_q;
    mcc_phy_s st_d;

    logic rst_pin_n;
    logic tx_s;
    logic mdc_s;
    logic mdio_s;
    logic ref_s;
    logic in_reset;
    logic mdc_rise;
    logic mdc_fall;
    logic rx_act;
    logic sym_two_zero;
    logic [4:0] s_vec;

    // Pins from the MAC end, two flops each
    mcc_sync #(.W(5)) u_sync (
        .clk(clk),
        .reset(reset),
        .d({link.hw_reset_low, link.tx_enable, link.mdc, link.mdio_in,
            link.ref_clk}),
        .q(s_vec)
    );

    assign rst_pin_n = s_vec[4];
    assign tx_s = s_vec[3];
    assign mdc_s = s_vec[2];
    assign mdio_s = s_vec[1];
    assign ref_s = s_vec[0];

    assign in_reset = reset || !rst_pin_n;
    assign mdc_rise = mdc_s && !st_q.mdc_prev;
    assign mdc_fall = !mdc_s && st_q.mdc_prev;

    // Two zeros at least two bit positions apart somewhere in the symbol
    always_comb begin
        sym_two_zero = 1'b0;
        for (int i = 0; i < SYMW; i++) begin
            for (int j = i + 2; j < SYMW; j++) begin
                if (!rx_symbol[i] && !rx_symbol[j]) begin
                    sym_two_zero = 1'b1;
                end
            end
        end
    end
    // Activity source chosen by speed
    assign rx_act = speed_100 ? sym_two_zero : rx_unsquelched;

    always_comb begin
        st_d = st_q;
        st_d.mdc_prev = mdc_s;
        st_d.ref_prev = ref_s;
        st_d.tx_prev = tx_s;
        if (ref_s != st_q.ref_prev) begin
            st_d.ref_seen = 1'b1;
        end

        // Heartbeat after end of transmission
        unique case (st_q.hb)
            HB_IDLE: begin
                if (st_q.tx_prev && !tx_s && !full_duplex) begin
                    st_d.hb = HB_WAIT;
                    st_d.hb_cnt = 8'(HB_DELAY_CYC);
                end
            end
            HB_WAIT: begin
                // Quiet gap before the pulse
                st_d.hb_cnt = st_q.hb_cnt - 8'h01;
                if (st_q.hb_cnt == 8'h01) begin
                    st_d.hb = HB_PULSE;
                    st_d.hb_cnt = 8'(HB_PULSE_CYC);
                end
            end
            HB_PULSE: begin
                // Pulse length counts down
                st_d.hb_cnt = st_q.hb_cnt - 8'h01;
                if (st_q.hb_cnt == 8'h01) begin
                    st_d.hb = HB_IDLE;
                end
            end
        endcase

        // Management slave: sample on MDC rise, drive after MDC fall
        if (mdc_rise) begin
            // Read data shifts out on falls only
            if (!st_q.drive) begin
                st_d.sh = {st_q.sh[14:0], mdio_s};
            end
            st_d.bit_cnt = st_q.bit_cnt + 6'h01;
            // Idle ones keep the frame counter at zero
            if (st_q.bit_cnt == 6'h00 && mdio_s) begin
                st_d.bit_cnt = 6'h00;
            end
            // Opcode 10 marks a read
            if (st_q.bit_cnt == 6'h04) begin
                st_d.is_read = st_q.sh[1:0] == 2'h2;
            end
            // Last register address bit
            if (st_q.bit_cnt == 6'h0D) begin
                st_d.reg_addr = {st_q.sh[3:0], mdio_s};
            end
            // Turnaround: load read data, first driven bit is zero
            if (st_q.bit_cnt == 6'h0E && st_q.is_read) begin
                st_d.sh = 16'h0000;
                st_d.sh[HB_SUPPRESS_BIT] = st_q.hb_suppress;
                st_d.drive = 1'b1;
                st_d.mdio_out = 1'b0;
            end
            // End of frame: a write to the suppress register lands
            if (st_q.bit_cnt == 6'h1F) begin
                st_d.bit_cnt = 6'h00;
                st_d.drive = 1'b0;
                if (!st_q.is_read && st_q.reg_addr == HB_SUPPRESS_REG) begin
                    st_d.hb_suppress = st_q.sh[HB_SUPPRESS_BIT - 1];
                end
            end
        end
        if (mdc_fall && st_q.drive && st_q.bit_cnt >= 6'h10) begin
            st_d.mdio_out = st_q.sh[15];
            st_d.sh = {st_q.sh[14:0], 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        if (in_reset) begin
            st_q <= '0;
            st_q.hb <= HB_IDLE;
            // MDC taken as high: no false rise after reset
            st_q.mdc_prev <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs are plain gates, free of any data clock
    always_comb begin
        link.collision = 1'b0;
        link.carrier_sense = 1'b0;
        if (!in_reset) begin
            if (!full_duplex) begin
                link.collision = (rx_act && tx_s)
                    || (st_q.hb == HB_PULSE && !st_q.hb_suppress);
            end
            if (full_duplex || repeater_mode) begin
                link.carrier_sense = rx_act;
            end else begin
                link.carrier_sense = rx_act || tx_s;
            end
        end
    end
    assign link.speed_indicator = speed_100;
    assign link.phy_mdio_out = st_q.mdio_out;
    assign link.phy_mdio_oe_n = !st_q.drive;
    assign ref_clk_seen = st_q.ref_seen;
endmodule

/* core/mcc_pkg.sv */
/*
 Package for the carrier, collision and status block and its MAC-side peer.
 Assumes one 50 MHz system clock on both ends.
*/
package mcc_pkg;
    localparam int SYM_W = 10;
    localparam int HB_DELAY_CYC = 8;
    localparam int HB_PULSE_CYC = 4;
    localparam int MDC_DIV = 4;
    localparam int MGMT_REG_W = 16;
    localparam logic [4:0] HB_SUPPRESS_REG = 5'h12;
    localparam int HB_SUPPRESS_BIT = 2;
    localparam int CTRL_RESET_BIT = 0;
    localparam int CTRL_SPEED_BIT = 1;
    localparam int CTRL_DUPLEX_BIT = 2;
    localparam int CTRL_REPEATER_BIT = 3;
    localparam int CTRL_HBSUP_BIT = 4;
    localparam int CTRL_W = 5;
    localparam logic [4:0] OFF_CTRL = 5'h00;
    localparam logic [4:0] OFF_STATUS = 5'h04;
    localparam int STAT_CRS_BIT = 0;
    localparam int STAT_COL_BIT = 1;
    localparam int STAT_SPEED_BIT = 2;
    localparam int STAT_COLSEEN_BIT = 3;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [CTRL_W-1:0] CTRL_RESET_VAL = 5'h01;
endpackage

/* core/mcc_sync.sv */
/*
 Two-flop synchroniser for pins from outside the clock domain.
 Assumes clk and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module mcc_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } mcc_sync_s;
    mcc_sync_s st_q;
    mcc_sync_s st_d;
    always_comb begin
        st_d.s1 = d;
        st_d.s2 = st_q.s1;
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
    assign q = st_q.s2;
endmodule

/* verification/mcc_chk.sv */
/*
 Checker for carrier, collision, speed and MDC pins of the link.
 Assumes the bench instantiates it beside the interface.
*/
`timescale 1ns/1ns
module mcc_chk
    import mcc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic carrier_sense,
    input wire logic collision,
    input wire logic speed_indicator,
    input wire logic hw_reset_low,
    input wire logic tx_enable,
    input wire logic mdc,
    input wire logic speed_100,
    input wire logic full_duplex,
    input wire logic repeater_mode,
    input wire logic rx_unsquelched,
    input wire logic [SYM_W-1:0] rx_symbol,
    input wire logic phy_mdio_oe_n,
    input wire logic sta_mdio_oe_n
);
    logic act;
    logic [4:0] idle_q;
    function automatic logic two_zero(logic [SYM_W-1:0] s);
        for (int i = 0; i < SYM_W; i++) begin
            for (int j = i + 2; j < SYM_W; j++) begin
                if (!s[i] && !s[j]) begin
                    return 1'b1;
                end
            end
        end
        return 1'b0;
    endfunction
    assign act = speed_100 ? two_zero(rx_symbol) : rx_unsquelched;
    // Cycles since transmit ended, saturating
    always_ff @(posedge clk) begin
        if (reset || tx_enable) begin
            idle_q <= 5'h00;
        end else if (idle_q != 5'h1F) begin
            idle_q <= idle_q + 5'h01;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    speed_follow_a: assert property (speed_indicator == speed_100)
        else $error("speed indicator differs from speed");
    fd_no_col_a: assert property (full_duplex |-> !collision)
        else $error("collision in full duplex");
    reset_quiet_a: assert property (
        (!hw_reset_low)[*4] |-> !carrier_sense && !collision)
        else $error("carrier or collision during reset");
    rx_carrier_a: assert property (
        hw_reset_low[*4] ##0 act |-> carrier_sense)
        else $error("no carrier on receive activity");
    fd_rx_only_a: assert property (
        (full_duplex || repeater_mode) && !act |-> !carrier_sense)
        else $error("carrier without receive activity");
    tx_carrier_a: assert property (
        (hw_reset_low && tx_enable)[*4] ##0
        (!full_duplex && !repeater_mode) |-> carrier_sense)
        else $error("no carrier while transmitting");
    tx_col_a: assert property (
        (hw_reset_low && tx_enable)[*4] ##0 (!full_duplex && act)
        |-> collision)
        else $error("no collision on receive while transmitting");
    idle_col_a: assert property (idle_q >= 5'h14 |-> !collision)
        else $error("collision long after transmit ended");
    mdc_hold_a: assert property (
        $changed(mdc) |=> $stable(mdc)[*3])
        else $error("management clock phase too short");
    mdio_one_driver_a: assert property (
        !(!phy_mdio_oe_n && !sta_mdio_oe_n))
        else $error("both ends drive the management data wire");
endmodule

/* verification/tb.sv */
/*
 Testbench joining both ends through the interface.
 Assumes AXI4-Lite access to the MAC end registers.
*/
`timescale 1ns/1ns
module tb
    import mcc_pkg::*;
;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic speed_100 = 1'b0;
    logic full_duplex = 1'b0;
    logic repeater_mode = 1'b0;
    logic rx_unsquelched = 1'b0;
    logic [SYM_W-1:0] rx_symbol = 10'h3FF;
    logic tx_request = 1'b0;
    logic ref_osc = 1'b0;
    logic ref_seen, awready, wready, bvalid, arready, rvalid;
    logic [4:0] awaddr = 5'h00;
    logic [4:0] araddr = 5'h00;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic arvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [31:0] rdata, d;
    logic [1:0] bresp, rresp, r;
    logic sta_drove = 1'b0;
    logic [31:0] seed = 32'hB19AE55A;
    logic u, a;
    logic [SYM_W-1:0] s;
    int err_total = 0;
    int num_checks = 0;
    int n;
    mcc_if link();
    // Pulled-up shared management wire
    assign link.mdio_in = ((!link.phy_mdio_oe_n && !link.phy_mdio_out) ||
        (!link.sta_mdio_oe_n && !link.sta_mdio_out)) ? 1'b0 : 1'b1;
    always #10 clk = ~clk;
    initial begin
        #7;
        forever #80 ref_osc = ~ref_osc;
    end
    always @(posedge clk) begin
        if (!link.sta_mdio_oe_n) sta_drove <= 1'b1;
    end
    mcc_phy u_mcc_phy (.clk(clk), .reset(reset), .link(link),
        .speed_100(speed_100), .full_duplex(full_duplex),
        .repeater_mode(repeater_mode), .rx_unsquelched(rx_unsquelched),
        .rx_symbol(rx_symbol), .ref_clk_seen(ref_seen));
    mcc_mac u_mcc_mac (.clk(clk), .reset(reset), .link(link),
        .tx_request(tx_request), .ref_osc(ref_osc), .s_awaddr(awaddr),
        .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
        .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(wready),
        .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(1'b1),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
        .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
        .s_rready(1'b1));
    mcc_chk u_mcc_chk (.clk(clk), .reset(reset),
        .carrier_sense(link.carrier_sense), .collision(link.collision),
        .speed_indicator(link.speed_indicator),
        .hw_reset_low(link.hw_reset_low), .tx_enable(link.tx_enable),
        .mdc(link.mdc), .speed_100(speed_100), .full_duplex(full_duplex),
        .repeater_mode(repeater_mode), .rx_unsquelched(rx_unsquelched),
        .rx_symbol(rx_symbol), .phy_mdio_oe_n(link.phy_mdio_oe_n),
        .sta_mdio_oe_n(link.sta_mdio_oe_n));
    function automatic logic [31:0] lfsr(logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic two_zero(logic [SYM_W-1:0] v);
        for (int i = 0; i < SYM_W; i++) begin
            for (int j = i + 2; j < SYM_W; j++) begin
                if (!v[i] && !v[j]) return 1'b1;
            end
        end
        return 1'b0;
    endfunction
    task automatic chk(input string nm, input logic [31:0] seen,
        input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic axi_write(input logic [4:0] ad, input logic [31:0] v);
        logic ag, wg, bg;
        ag = 1'b0;
        wg = 1'b0;
        bg = 1'b0;
        awaddr <= ad;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!bg) begin
            @(posedge clk);
            if (!ag && awready === 1'b1) begin
                ag = 1'b1;
                awvalid <= 1'b0;
            end
            if (!wg && wready === 1'b1) begin
                wg = 1'b1;
                wvalid <= 1'b0;
            end
            if (bvalid === 1'b1) begin
                bg = 1'b1;
                chk("bresp", 32'(bresp), 32'(RESP_OKAY));
            end
        end
    endtask
    task automatic axi_read(input logic [4:0] ad);
        logic ag, rg;
        ag = 1'b0;
        rg = 1'b0;
        araddr <= ad;
        arvalid <= 1'b1;
        while (!rg) begin
            @(posedge clk);
            if (!ag && arready === 1'b1) begin
                ag = 1'b1;
                arvalid <= 1'b0;
            end
            if (rvalid === 1'b1) begin
                rg = 1'b1;
                d = rdata;
                r = rresp;
            end
        end
    endtask
    task automatic heartbeat(input logic fd, input int expn);
        full_duplex <= fd;
        repeater_mode <= 1'b0;
        speed_100 <= 1'b0;
        rx_unsquelched <= 1'b0;
        tx_request <= 1'b1;
        repeat (10) @(posedge clk);
        tx_request <= 1'b0;
        n = 0;
        repeat (40) begin
            @(posedge clk);
            if (link.collision === 1'b1) n++;
        end
        chk("heartbeat cycles", n, expn);
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_total++;
        stop_test();
    end
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        chk("reset pin", 32'(link.hw_reset_low), 32'h0);
        axi_read(OFF_CTRL);
        chk("ctrl", d, 32'(CTRL_RESET_VAL));
        chk("ctrl resp", 32'(r), 32'(RESP_OKAY));
        axi_read(5'h08);
        chk("unmapped resp", 32'(r), 32'(RESP_SLVERR));
        axi_write(OFF_CTRL, 32'h0);
        repeat (8) @(posedge clk);
        chk("reset pin", 32'(link.hw_reset_low), 32'h1);
        chk("ref seen", 32'(ref_seen), 32'h1);
        for (int m = 0; m < 16; m++) begin
            full_duplex <= m[0];
            repeater_mode <= m[1];
            speed_100 <= m[2];
            tx_request <= m[3];
            repeat (20) @(posedge clk);
            chk("speed", 32'(link.speed_indicator), 32'(m[2]));
            for (int k = 0; k < 24; k++) begin
                seed = lfsr(seed);
                s = (k == 0) ? 10'h3FC : (k == 1) ? 10'h3FA : seed[9:0];
                u = seed[12];
                rx_symbol <= s;
                rx_unsquelched <= u;
                a = m[2] ? two_zero(s) : u;
                @(posedge clk);
                chk("crs", 32'(link.carrier_sense),
                    32'(a | (m[3] & !m[0] & !m[1])));
                chk("col", 32'(link.collision), 32'(!m[0] & m[3] & a));
            end
        end
        heartbeat(1'b1, 0);
        heartbeat(1'b0, HB_PULSE_CYC);
        axi_read(OFF_STATUS);
        chk("col seen", 32'(d[STAT_COLSEEN_BIT]), 32'h1);
        axi_write(OFF_STATUS, 32'h8);
        rx_unsquelched <= 1'b1;
        repeat (6) @(posedge clk);
        axi_read(OFF_STATUS);
        chk("status", d & 32'hB, 32'h1);
        rx_unsquelched <= 1'b0;
        axi_write(OFF_CTRL, 32'h1 << CTRL_HBSUP_BIT);
        repeat (1500) @(posedge clk);
        chk("mgmt drive", 32'(sta_drove), 32'h1);
        heartbeat(1'b0, 0);
        stop_test();
    end
endmodule
